// ### hw/adcf_result_fmt.v
// result formatting, mode and channel selection for a 10-bit converter
// assumes an APB master on pclk and a converter core on the same clock
// that delivers a unity-gain signed code at the 1024/vref scale
`timescale 1ns/1ps
`include "adcf_map.vh"

module adcf_result_fmt (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire conv_busy,
  input wire conv_done,
  input wire [11:0] conv_raw,
  output wire [5:0] channel_select_field,
  output wire [1:0] reference_select_field,
  output wire gain_select_bit,
  output wire diff_mode,
  output wire bipolar_mode,
  output wire temp_sensor_en,
  output wire internal_ref_sel,
  output wire conv_done_flag,
  output wire irq
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire setup_ph;
  wire access_ph;
  wire wr_en;
  wire rd_setup;
  wire hit_chan;
  wire hit_ctrl;
  wire hit_low;
  wire hit_high;
  wire hit_stat;
  wire hit_mask;
  wire mapped;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en = access_ph & pwrite;
  assign rd_setup = setup_ph & ~pwrite;
  assign hit_chan = (paddr == `ADCF_ADDR_CHAN_REF);
  assign hit_ctrl = (paddr == `ADCF_ADDR_CTRL_B);
  assign hit_low = (paddr == `ADCF_ADDR_RES_LOW);
  assign hit_high = (paddr == `ADCF_ADDR_RES_HIGH);
  assign hit_stat = (paddr == `ADCF_ADDR_STATUS);
  assign hit_mask = (paddr == `ADCF_ADDR_MASK);
  assign mapped = hit_chan | hit_ctrl | hit_low | hit_high | hit_stat | hit_mask;

  // zero wait states
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;

  // ****************************************************************
  // software registers
  // ****************************************************************
  reg [7:0] chan_ref_q;
  reg [7:0] ctrl_b_q;
  reg done_mask_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_ref_q <= `ADCF_CHAN_REF_RST;
      ctrl_b_q <= `ADCF_CTRL_B_RST;
      done_mask_q <= 1'b0;
    end else if (wr_en) begin
      if (hit_chan) begin
        chan_ref_q <= pwdata[7:0];
      end
      if (hit_ctrl) begin
        ctrl_b_q <= pwdata[7:0];
      end
      if (hit_mask) begin
        done_mask_q <= pwdata[`ADCF_DONE_BIT];
      end
    end
  end

  // ****************************************************************
  // selection in effect
  // ****************************************************************
  // copies follow the software registers only while idle, so a write
  // during a conversion takes hold once it has finished
  wire [5:0] sel_chan_d;
  wire [1:0] sel_ref_d;
  wire [2:0] sel_grp_d;
  wire sel_se_lo_d;
  wire sel_se_hi_d;
  wire sel_diff_d;
  wire sel_gain_d;
  wire sel_temp_d;
  wire sel_iref_d;

  assign sel_chan_d = chan_ref_q[`ADCF_CHAN_MSB:`ADCF_CHAN_LSB];
  assign sel_ref_d = chan_ref_q[`ADCF_REF_MSB:`ADCF_REF_LSB];
  assign sel_grp_d = sel_chan_d[`ADCF_GRP_MSB:`ADCF_GRP_LSB];
  // single-ended: groups 000xxx and 100000..100010, all else differential
  assign sel_se_lo_d = (sel_grp_d == `ADCF_GRP_SE_LO);
  assign sel_se_hi_d = (sel_grp_d == `ADCF_GRP_SE_HI) && (sel_chan_d < `ADCF_CHAN_OFFS_LO);
  assign sel_diff_d = ~(sel_se_lo_d | sel_se_hi_d);
  // gain of twenty only for differential channels
  assign sel_gain_d = sel_diff_d & sel_chan_d[`ADCF_GAIN_BIT];
  assign sel_temp_d = (sel_chan_d == `ADCF_CHAN_TEMP);
  assign sel_iref_d = (sel_ref_d == `ADCF_REF_INT_1V1);

  // decoded flags registered with the copies, so they never glitch
  reg [5:0] act_chan_q;
  reg [1:0] act_ref_q;
  reg act_bip_q;
  reg act_diff_q;
  reg act_gain_q;
  reg act_temp_q;
  reg act_iref_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_chan_q <= `ADCF_CHAN_RST;
      act_ref_q <= `ADCF_REF_RST;
      act_bip_q <= 1'b0;
      act_diff_q <= 1'b0;
      act_gain_q <= 1'b0;
      act_temp_q <= 1'b0;
      act_iref_q <= 1'b0;
    end else if (!conv_busy) begin
      act_chan_q <= sel_chan_d;
      act_ref_q <= sel_ref_d;
      act_bip_q <= ctrl_b_q[`ADCF_BIPOLAR_BIT];
      act_diff_q <= sel_diff_d;
      act_gain_q <= sel_gain_d;
      act_temp_q <= sel_temp_d;
      act_iref_q <= sel_iref_d;
    end
  end

  assign channel_select_field = act_chan_q;
  assign reference_select_field = act_ref_q;
  assign gain_select_bit = act_gain_q;
  assign diff_mode = act_diff_q;
  assign bipolar_mode = act_bip_q;
  assign temp_sensor_en = act_temp_q;
  assign internal_ref_sel = act_iref_q;

  // ****************************************************************
  // result formatting
  // ****************************************************************
  wire signed [16:0] raw_ext;
  wire signed [16:0] gained;
  wire signed [16:0] half;
  reg [9:0] fmt_code;

  assign raw_ext = {{5{conv_raw[11]}}, conv_raw};
  // gain of twenty only for differential channels
  assign gained = gain_select_bit ? raw_ext * `ADCF_GAIN_HIGH : raw_ext;
  assign half = gained >>> 1;

  reg [9:0] bip_code;
  reg [9:0] uni_code;

  // two's complement, 512 scale, no clipping at zero
  always @* begin
    bip_code = `ADCF_BIP_MIN_CODE;
    if (half > `ADCF_BIP_MAX) begin
      bip_code = `ADCF_BIP_MAX_CODE;
    end else if (half < `ADCF_BIP_MIN) begin
      bip_code = `ADCF_BIP_MIN_CODE;
    end else begin
      bip_code = half[9:0];
    end
  end

  // single-ended and unipolar: one-sided 0..full code
  always @* begin
    uni_code = `ADCF_UNI_MIN_CODE;
    if (gained > `ADCF_UNI_MAX) begin
      uni_code = `ADCF_UNI_MAX_CODE;
    end else if (gained < `ADCF_UNI_MIN) begin
      uni_code = `ADCF_UNI_MIN_CODE;
    end else begin
      uni_code = gained[9:0];
    end
  end

  // bipolar coding only applies to differential channels
  always @* begin
    fmt_code = uni_code;
    if (act_diff_q && act_bip_q) begin
      fmt_code = bip_code;
    end
  end

  // ****************************************************************
  // result bytes
  // ****************************************************************
  reg [9:0] result_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= `ADCF_RESULT_RST;
    end else if (conv_done) begin
      result_q <= fmt_code;
    end
  end

  wire [7:0] result_low_byte;
  wire [7:0] result_high_byte;

  assign result_low_byte = result_q[7:0];
  // bit 9 is the sign in bipolar mode
  assign result_high_byte = {6'h00, result_q[9:8]};

  // ****************************************************************
  // done flag and interrupt
  // ****************************************************************
  reg done_q;
  reg irq_q;
  wire done_clr;
  wire done_d;
  wire mask_d;

  assign done_clr = wr_en & hit_stat & pwdata[`ADCF_DONE_BIT];
  // a new completion wins over a clear in the same cycle
  assign done_d = (done_q & ~done_clr) | conv_done;
  // mask as it stands after this edge, so irq keeps step with the flag
  assign mask_d = (wr_en & hit_mask) ? pwdata[`ADCF_DONE_BIT] : done_mask_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      done_q <= done_d;
      irq_q <= done_d & mask_d;
    end
  end

  assign conv_done_flag = done_q;
  assign irq = irq_q;

  // ****************************************************************
  // read data
  // ****************************************************************
  // captured in the setup phase so it stands through the access phase
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (1'b1)
      hit_chan: begin
        rd_mux = {24'h000000, chan_ref_q};
      end
      hit_ctrl: begin
        rd_mux = {24'h000000, ctrl_b_q};
      end
      hit_low: begin
        rd_mux = {24'h000000, result_low_byte};
      end
      hit_high: begin
        rd_mux = {24'h000000, result_high_byte};
      end
      hit_stat: begin
        rd_mux = {31'h00000000, done_q};
      end
      hit_mask: begin
        rd_mux = {31'h00000000, done_mask_q};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule

// ### shared/adcf_map.vh
// register map, field positions and code limits of the result formatter
// assumes inclusion by the formatter module only
`ifndef ADCF_MAP_VH
`define ADCF_MAP_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADCF_ADDR_CHAN_REF 8'h00
`define ADCF_ADDR_CTRL_B 8'h04
`define ADCF_ADDR_RES_LOW 8'h08
`define ADCF_ADDR_RES_HIGH 8'h0c
`define ADCF_ADDR_STATUS 8'h10
`define ADCF_ADDR_MASK 8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define ADCF_CHAN_MSB 5
`define ADCF_CHAN_LSB 0
`define ADCF_REF_MSB 7
`define ADCF_REF_LSB 6
`define ADCF_BIPOLAR_BIT 7
`define ADCF_DONE_BIT 0
`define ADCF_GAIN_BIT 0
`define ADCF_GRP_MSB 5
`define ADCF_GRP_LSB 3

// ****************************************************************
// reset values
// ****************************************************************
`define ADCF_CHAN_REF_RST 8'h00
`define ADCF_CTRL_B_RST 8'h00
`define ADCF_RESULT_RST 10'h000
`define ADCF_CHAN_RST 6'h00
`define ADCF_REF_RST 2'h0

// ****************************************************************
// codes and limits
// ****************************************************************
`define ADCF_CHAN_TEMP 6'h22
`define ADCF_CHAN_OFFS_LO 6'h23
`define ADCF_GRP_SE_LO 3'h0
`define ADCF_GRP_SE_HI 3'h4
`define ADCF_REF_INT_1V1 2'h2
`define ADCF_GAIN_HIGH 17'sh00014
`define ADCF_UNI_MAX 17'sh003ff
`define ADCF_UNI_MIN 17'sh00000
`define ADCF_BIP_MAX 17'sh001ff
`define ADCF_BIP_MIN 17'sh1fe00
`define ADCF_UNI_MAX_CODE 10'h3ff
`define ADCF_UNI_MIN_CODE 10'h000
`define ADCF_BIP_MAX_CODE 10'h1ff
`define ADCF_BIP_MIN_CODE 10'h200

`endif

// ### verif/adcf_conv_model.sv
// converter core stand-in: busy for lat+1 cycles, then a done pulse
// assumes go is raised for one cycle while idle
`timescale 1ns/1ps
module adcf_conv_model (
  input logic pclk,
  input logic presetn,
  input logic go,
  input logic [3:0] lat,
  input logic [11:0] raw,
  output logic conv_busy,
  output logic conv_done,
  output logic [11:0] conv_raw
);
  logic [3:0] cnt_q;
  logic [11:0] val_q;
  // code is valid only with the done pulse
  assign conv_raw = conv_done ? val_q : ~val_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      val_q <= 12'h000;
      conv_busy <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (go && !conv_busy) begin
        conv_busy <= 1'b1;
        cnt_q <= lat;
        val_q <= raw;
      end else if (conv_busy) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          conv_busy <= 1'b0;
          conv_done <= 1'b1;
        end
      end
    end
  end
endmodule

// ### verif/adcf_properties.sv
// port assertions of the result formatter
// assumes binding to adcf_result_fmt
`timescale 1ns/1ps
module adcf_properties (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  input logic conv_busy,
  input logic conv_done,
  input logic [5:0] channel_select_field,
  input logic [1:0] reference_select_field,
  input logic gain_select_bit,
  input logic diff_mode,
  input logic temp_sensor_en,
  input logic internal_ref_sel,
  input logic conv_done_flag,
  input logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [5:0] c = channel_select_field;
  wire clr = psel && penable && pwrite && paddr == 8'h10 && pwdata[0];
  a_ready_high: assert property (pready) else $error("pready low");
  a_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("no error on unmapped address");
  a_done_flag: assert property (conv_done |=> conv_done_flag)
    else $error("done flag not set");
  a_flag_holds: assert property (conv_done_flag && !clr |=> conv_done_flag)
    else $error("done flag lost");
  a_irq_cause: assert property (irq |-> conv_done_flag) else $error("irq without flag");
  a_temp_select: assert property (temp_sensor_en == (c == 6'h22))
    else $error("temp sensor enable wrong");
  a_ref_internal: assert property (internal_ref_sel == (reference_select_field == 2'h2))
    else $error("internal reference select wrong");
  a_diff_decode: assert property (diff_mode == ((c >= 6'h08 && c <= 6'h1f) || c >= 6'h23))
    else $error("differential decode wrong");
  a_gain_pick: assert property (gain_select_bit == (diff_mode && c[0]))
    else $error("gain select wrong");
  a_sel_locked: assert property (conv_busy |=> $stable(c) && $stable(reference_select_field))
    else $error("selection moved during conversion");
endmodule

bind adcf_result_fmt adcf_properties u_props (.*);

// ### verif/adcf_result_fmt_bench.sv
// self-checking bench of the result formatter
// assumes the converter stand-in and the bound checker
`timescale 1ns/1ps
module adcf_result_fmt_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, x;
  logic [3:0] lat = 4'h0;
  logic [11:0] raw = 12'h000, conv_raw;
  logic [31:0] prdata;
  logic [5:0] channel_select_field;
  logic [1:0] reference_select_field;
  logic pready, pslverr, conv_busy, conv_done, gain_select_bit, diff_mode, bipolar_mode;
  logic temp_sensor_en, internal_ref_sel, conv_done_flag, irq;
  int fail_count = 0, checks = 0;
  adcf_result_fmt DUT (.*);
  adcf_conv_model u_model (.*);
  always #5 pclk = ~pclk;
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t no ready from slave", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic dif(input logic [5:0] c);
    return (c >= 6'h08 && c <= 6'h1f) || c >= 6'h23;
  endfunction
  function automatic logic [9:0] fmt(input logic [5:0] c, input logic b, input logic [11:0] r);
    int v, lo, hi;
    logic d;
    d = (c >= 6'h08 && c <= 6'h1f) || c >= 6'h23;
    v = $signed(r) * ((d && c[0]) ? 20 : 1);
    lo = 0;
    hi = 1023;
    if (b && d) begin
      v = v >>> 1;
      lo = -512;
      hi = 511;
    end
    v = v < lo ? lo : (v > hi ? hi : v);
    return v[9:0];
  endfunction
  task automatic conv(input logic [7:0] cr, input logic b, input logic [11:0] r, input logic m);
    int n;
    logic [31:0] lo;
    n = 0;
    apb(1'b1, 8'h00, {24'h0, cr});
    apb(1'b1, 8'h04, {24'h0, b, 7'h0});
    apb(1'b1, 8'h14, {31'h0, m});
    @(posedge pclk);
    raw <= r;
    go <= 1'b1;
    lat <= 4'($urandom);
    @(posedge pclk);
    go <= 1'b0;
    // no bus traffic and no other pin activity while converting
    while (conv_done_flag !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    if (conv_done_flag !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t conversion never finished", $time);
    end
    chk({24'h0, channel_select_field, reference_select_field},
        {24'h0, cr[5:0], cr[7:6]});
    chk({27'h0, diff_mode, gain_select_bit, temp_sensor_en, internal_ref_sel, bipolar_mode},
        {27'h0, dif(cr[5:0]), dif(cr[5:0]) & cr[0], cr[5:0] == 6'h22, cr[7:6] == 2'h2,
         b});
    chk({31'h0, irq}, {31'h0, m});
    apb(1'b0, 8'h08, 32'h0);
    lo = rd;
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[23:0], lo[7:0]}, {22'h0, fmt(cr[5:0], b, r)});
    apb(1'b1, 8'h10, 32'h1);
    @(posedge pclk);
    chk({30'h0, conv_done_flag, irq}, 32'h0);
  endtask
  initial begin
    void'($urandom(5031));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    conv(8'ha2, 1'b0, 12'h0c8, 1'b1);
    conv(8'h00, 1'b0, 12'h3ff, 1'b1);
    conv(8'h00, 1'b0, 12'h400, 1'b0);
    conv(8'h08, 1'b0, 12'hf00, 1'b1);
    conv(8'h08, 1'b1, 12'hc00, 1'b1);
    conv(8'h09, 1'b1, 12'h040, 1'b1);
    conv(8'h09, 1'b1, 12'h010, 1'b0);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'ha0);
    // selection written mid-conversion must wait for the result
    raw <= 12'h010;
    lat <= 4'hf;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    chk({26'h0, channel_select_field}, 32'h9);
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h40);
    chk({26'h0, channel_select_field}, 32'h0);
    // bipolar on, then a reset in mid-run must bring back unipolar
    apb(1'b1, 8'h04, 32'h80);
    repeat (2) @(posedge pclk);
    chk({31'h0, bipolar_mode}, 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], bipolar_mode}, 32'h0);
    repeat (24) begin
      x = $urandom;
      conv(x[7:0], x[8], x[20:9], x[21]);
    end
    end_of_test;
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule
